// ===== hw/rph_pkg.sv
// Shared constants and types for the radio packet handler
package rph_pkg;
   localparam int unsigned RPH_LEN_W = 11;
   localparam logic [10:0] RPH_LEN_MAX = 11'h7ff;
   localparam logic [7:0] RPH_VAR_LEN_MAX = 8'hff;
   localparam int unsigned RPH_FIFO_DEPTH = 64;
   localparam int unsigned RPH_CNT_W = 7;
   localparam int unsigned RPH_PRE_W = 16;
   localparam int unsigned RPH_SYNC_W = 64;
   localparam int unsigned RPH_SYNC_CNT_W = 4;
   localparam logic [7:0] RPH_PREAMBLE_BYTE = 8'haa;
   localparam logic [15:0] RPH_CRC_SEED = 16'h1d0f;
   localparam logic [15:0] RPH_CRC_POLY = 16'h1021;
   localparam logic [8:0] RPH_WHITE_SEED = 9'h1ff;
   localparam logic [2:0] RPH_BIT_LAST = 3'h7;
   localparam logic [1:0] RPH_DC_NONE = 2'h0;
   localparam logic [1:0] RPH_DC_MANCH = 2'h1;
   localparam logic [1:0] RPH_DC_WHITE = 2'h2;

   // Static frame configuration
   typedef struct packed {
      logic frame_format_select;
      logic [10:0] payload_length_setting;
      logic transmit_start_condition;
      logic queue_fill_condition;
      logic sync_word_enable;
      logic [2:0] sync_size;
      logic [63:0] sync_value;
      logic [15:0] preamble_len;
      logic checksum_enable;
      logic checksum_fail_keep;
      logic addr_check_enable;
      logic [7:0] own_station_id;
      logic [1:0] dc_balance_select;
      logic [5:0] queue_threshold_setting;
   } rph_cfg_t;

   // Status flags towards the host
   typedef struct packed {
      logic checksum_match_flag;
      logic rx_frame_complete_flag;
      logic tx_frame_done_flag;
      logic queue_level_flag;
      logic queue_empty_flag;
      logic queue_full_flag;
   } rph_stat_t;
endpackage

// ===== hw/rph_queue.sv
// Byte queue between host port and framer
`timescale 1ns/1ps
`default_nettype none
module rph_queue #(
   parameter int unsigned DEPTH = 64,
   parameter int unsigned CW = 7
) (
   // Clock and control
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   input wire logic i_clear,
   // Write side
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   // Read side
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   // Fill level
   output logic [CW-1:0] o_count
);
   logic [7:0] mem_q [DEPTH];
   logic [CW-2:0] wp_q, rp_q;
   logic [CW-1:0] cnt_q;
   wire do_wr = i_wr && (cnt_q != CW'(DEPTH));
   wire do_rd = i_rd && (cnt_q != '0);

   assign o_rdata = mem_q[rp_q];
   assign o_count = cnt_q;

   // Pointers wrap naturally at a power-of-two depth
   always_ff @(posedge i_clk) begin
      if (!i_nrst || (i_ce && i_clear)) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else if (i_ce) begin
         if (do_wr) begin
            mem_q[wp_q] <= i_wdata;
            wp_q <= wp_q + 1'b1;
         end
         if (do_rd) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + CW'(do_wr) - CW'(do_rd);
      end
   end
endmodule
`default_nettype wire

// ===== hw/rph_top.sv
// Packet framer and deframer around the byte queue
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1: Format 0, nonzero length: fixed frames
// RQ2: Fixed length is 1 to 2047 bytes
// RQ3: Format 1 selects variable-length frames
// RQ4: Length byte excludes itself, max 255
// RQ5: Format 0, zero length: unlimited frames
// RQ6: Unlimited: tx CRC, no rx checks/flags
// RQ7: Unlimited no-sync rx: raw, fill condition
// RQ8: Tx adds preamble, sync, CRC, coding
// RQ9: Preamble or constant until start condition
// RQ10: Condition 1: start after first byte
// RQ11: Condition 0: start at threshold plus one
// RQ12: Prefilled queue starts immediately on tx
// RQ13: Rx strips framing, queues payload only
// RQ14: Fixed rx length from length setting
// RQ15: Variable rx: load length, discard oversize
// RQ16: Address byte checked, mismatch stops reception
// RQ17: CRC checked, match flag, ready on pin
// RQ18: CRC fail clears queue unless keep
// RQ19: Queue readable in sleep or standby
// RQ20: Host refills queue for large tx
// RQ21: Host drains queue for large rx
// RQ22: Sent flag after last bit
// RQ23: Manchester on payload/CRC when select 01
// RQ24: Whitening by 9-bit LFSR when select 10
// RQ25: Fixed tx ends after length, then CRC
module rph_top import rph_pkg::*; #(
   parameter int unsigned DEPTH = RPH_FIFO_DEPTH
) (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Configuration and mode
   input wire rph_cfg_t i_cfg,
   input wire logic i_tx_mode,
   input wire logic i_rx_mode,
   // Host queue port
   input wire logic i_host_wr,
   input wire logic [7:0] i_host_wdata,
   input wire logic i_host_rd,
   output logic [7:0] o_host_rdata,
   // Modem bit stream
   output logic o_tx_bit,
   output logic o_tx_bit_valid,
   input wire logic i_rx_bit,
   input wire logic i_rx_bit_valid,
   input wire logic i_rx_sync_found,
   // Status
   output rph_stat_t o_stat,
   output logic o_event_pin_zero
);
   typedef enum logic [2:0] {
      TX_IDLE, TX_PRE, TX_SYNC, TX_PAY, TX_CRC, TX_DONE
   } tx_st_t;
   typedef enum logic [1:0] {RX_HUNT, RX_PAY, RX_CRC} rx_st_t;

   // CRC-16 over one bit, shared by both directions
   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic b);
      crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? RPH_CRC_POLY : 16'h0000);
   endfunction
   function automatic logic [8:0] lfsr_step(input logic [8:0] l);
      lfsr_step = {l[0] ^ l[5], l[8:1]};
   endfunction

   // Queue wiring
   logic q_wr, q_rd, q_clr;
   logic [7:0] q_wdata, q_rdata;
   logic [RPH_CNT_W-1:0] q_cnt;
   rph_queue #(.DEPTH(DEPTH), .CW(RPH_CNT_W)) u_queue (
      .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_clear(q_clr),
      .i_wr(q_wr), .i_wdata(q_wdata), .i_rd(q_rd),
      .o_rdata(q_rdata), .o_count(q_cnt)
   );

   // Frame kind decode
   wire len_zero = (i_cfg.payload_length_setting == '0);
   wire fmt_var = i_cfg.frame_format_select; // [RQ3]
   wire fmt_fixed = !fmt_var && !len_zero; // [RQ1]
   wire fmt_unlim = !fmt_var && len_zero; // [RQ5]

   // Transmit start condition; a prefilled queue counts at once
   wire tx_start_ok = i_cfg.transmit_start_condition ?
      (q_cnt != '0) : // [RQ10]
      (q_cnt >= RPH_CNT_W'(i_cfg.queue_threshold_setting) + 7'h01);
   // [RQ11] [RQ12]

   // Transmit state
   tx_st_t tx_st_q;
   logic [7:0] tx_sh_q;
   logic [2:0] tx_bit_q;
   logic [RPH_PRE_W-1:0] tx_pre_q;
   logic [RPH_SYNC_CNT_W-1:0] tx_sync_q;
   logic [RPH_LEN_W-1:0] tx_left_q; // [RQ2]
   logic tx_half_q, tx_crcb_q, tx_done_q;
   logic [15:0] tx_crc_q;
   logic [8:0] tx_lfsr_q;
   logic tx_bit_q2, tx_val_q;

   wire tx_coded = (tx_st_q == TX_PAY) || (tx_st_q == TX_CRC);
   wire manch = (i_cfg.dc_balance_select == RPH_DC_MANCH); // [RQ23]
   wire white = (i_cfg.dc_balance_select == RPH_DC_WHITE); // [RQ24]
   wire tx_raw = tx_sh_q[7];
   wire tx_wb = tx_raw ^ (white && tx_coded && tx_lfsr_q[0]); // [RQ24]
   // Manchester sends 10 for one, 01 for zero
   wire tx_line = (manch && tx_coded) ? (tx_wb ^ tx_half_q) : tx_wb;
   wire tx_step = !(manch && tx_coded) || tx_half_q;
   wire tx_byte_end = tx_step && (tx_bit_q == RPH_BIT_LAST);
   wire [RPH_LEN_W-1:0] tx_len0 = fmt_var ? // [RQ4]
      RPH_LEN_W'(q_rdata) + 11'h001 : i_cfg.payload_length_setting;
   wire tx_pay_last = !fmt_unlim && (tx_left_q == 11'h001); // [RQ25]
   wire [15:0] tx_crc_fin = ~crc_step(tx_crc_q, tx_raw);

   // Transmitter: one chip per enabled cycle
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         tx_st_q <= TX_IDLE;
         tx_sh_q <= '0;
         tx_bit_q <= '0;
         tx_pre_q <= '0;
         tx_sync_q <= '0;
         tx_left_q <= '0;
         tx_half_q <= 1'b0;
         tx_crcb_q <= 1'b0;
         tx_crc_q <= RPH_CRC_SEED;
         tx_lfsr_q <= RPH_WHITE_SEED;
         tx_done_q <= 1'b0;
         tx_bit_q2 <= 1'b0;
         tx_val_q <= 1'b0;
      end else if (i_ce) begin
         tx_done_q <= 1'b0;
         tx_val_q <= i_tx_mode && !(tx_st_q inside {TX_IDLE, TX_DONE});
         tx_bit_q2 <= tx_line;
         if (!i_tx_mode) begin
            tx_st_q <= TX_IDLE;
         end else begin
            if (tx_step) begin
               tx_bit_q <= tx_bit_q + 3'h1;
               tx_sh_q <= {tx_sh_q[6:0], 1'b0};
               if (tx_st_q == TX_PAY) begin
                  tx_crc_q <= crc_step(tx_crc_q, tx_raw); // [RQ8] [RQ6]
               end
               if (tx_coded) begin
                  tx_lfsr_q <= lfsr_step(tx_lfsr_q);
               end
            end
            if (manch && tx_coded) begin
               tx_half_q <= !tx_half_q;
            end
            unique case (tx_st_q)
               TX_IDLE: begin
                  // Preamble, or a constant zero when preamble is off
                  tx_sh_q <= (i_cfg.preamble_len != '0) ?
                     RPH_PREAMBLE_BYTE : 8'h00; // [RQ9]
                  tx_bit_q <= '0;
                  tx_pre_q <= i_cfg.preamble_len;
                  tx_st_q <= TX_PRE;
               end
               TX_PRE: if (tx_byte_end) begin
                  if (tx_pre_q > 16'h0001 || !tx_start_ok) begin
                     tx_pre_q <= (tx_pre_q > 16'h0001) ?
                        tx_pre_q - 16'h0001 : tx_pre_q;
                     tx_sh_q <= (i_cfg.preamble_len != '0) ?
                        RPH_PREAMBLE_BYTE : 8'h00; // [RQ9]
                  end else begin
                     tx_st_q <= TX_SYNC;
                     tx_sync_q <= RPH_SYNC_CNT_W'(i_cfg.sync_size);
                     tx_sh_q <= i_cfg.sync_value[63:56];
                  end
               end
               TX_SYNC: if (tx_byte_end) begin
                  if (tx_sync_q != '0) begin
                     tx_sync_q <= tx_sync_q - 4'h1;
                     tx_sh_q <= i_cfg.sync_value[8*(6-
                        32'(RPH_SYNC_CNT_W'(i_cfg.sync_size) - tx_sync_q)) +: 8];
                  end else begin
                     tx_st_q <= TX_PAY;
                     tx_sh_q <= q_rdata;
                     tx_left_q <= tx_len0;
                     tx_crc_q <= RPH_CRC_SEED;
                     tx_lfsr_q <= RPH_WHITE_SEED;
                     tx_half_q <= 1'b0;
                  end
               end
               TX_PAY: if (tx_byte_end) begin
                  tx_left_q <= tx_left_q - 11'h001;
                  if (tx_pay_last || (fmt_unlim && q_cnt == '0)) begin
                     tx_st_q <= i_cfg.checksum_enable ? TX_CRC : TX_DONE;
                     tx_sh_q <= tx_crc_fin[15:8];
                     tx_crcb_q <= 1'b0;
                  end else begin
                     tx_sh_q <= q_rdata;
                  end
               end
               TX_CRC: if (tx_byte_end) begin
                  tx_crcb_q <= 1'b1;
                  tx_sh_q <= ~tx_crc_q[7:0];
                  if (tx_crcb_q) begin
                     tx_st_q <= TX_DONE; // [RQ8]
                  end
               end
               TX_DONE: begin
                  tx_done_q <= 1'b1; // [RQ22]
                  tx_st_q <= TX_IDLE;
               end
               default: tx_st_q <= TX_IDLE;
            endcase
         end
      end
   end
   wire tx_pop = i_ce && i_tx_mode && tx_byte_end &&
      ((tx_st_q == TX_SYNC && tx_sync_q == '0) ||
       (tx_st_q == TX_PAY && !tx_pay_last));

   // Receive input pins through a three-stage synchroniser
   logic [2:0] rb_s, rv_s, rs_s;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rb_s <= '0;
         rv_s <= '0;
         rs_s <= '0;
      end else if (i_ce) begin
         rb_s <= {rb_s[1:0], i_rx_bit};
         rv_s <= {rv_s[1:0], i_rx_bit_valid};
         rs_s <= {rs_s[1:0], i_rx_sync_found};
      end
   end
   // Valid strobes count on a rise, middle stage high and last stage still low
   wire rx_bit = rb_s[2];
   wire rx_val = rv_s[1] && !rv_s[2];
   wire rx_sync = rs_s[1] && !rs_s[2];

   // Receive state
   rx_st_t rx_st_q;
   logic [7:0] rx_sh_q;
   logic [2:0] rx_bit_q;
   logic [RPH_LEN_W-1:0] rx_left_q, rx_idx_q;
   logic rx_half_q, rx_crcb_q, rx_ready_q, rx_ok_q;
   logic [15:0] rx_crc_q, rx_got_q;
   logic [8:0] rx_lfsr_q;
   wire rx_raw_mode = fmt_unlim && !i_cfg.sync_word_enable; // [RQ7]
   wire rx_dec = !rx_raw_mode && rx_st_q != RX_HUNT;
   wire rx_manch = manch && rx_dec; // [RQ23]
   wire rx_db = rx_bit ^ (white && rx_dec && rx_lfsr_q[0]); // [RQ24]
   wire rx_take = rx_val && (!rx_manch || rx_half_q);
   wire [7:0] rx_byte = {rx_sh_q[6:0], rx_db};
   wire rx_byte_done = rx_take && rx_bit_q == RPH_BIT_LAST;
   wire rx_pay_byte = rx_byte_done && rx_st_q == RX_PAY;
   wire rx_len_bad = fmt_var && rx_idx_q == '0 &&
      RPH_LEN_W'(rx_byte) > i_cfg.payload_length_setting; // [RQ15]
   wire rx_addr_pos = fmt_var ? (rx_idx_q == 11'h001) : (rx_idx_q == '0);
   wire rx_addr_bad = i_cfg.addr_check_enable && !fmt_unlim &&
      rx_addr_pos && rx_byte != i_cfg.own_station_id; // [RQ16]
   wire rx_abort = rx_pay_byte && (rx_len_bad || rx_addr_bad);
   wire rx_pay_end = rx_pay_byte && !fmt_unlim && !rx_abort &&
      (fmt_var && rx_idx_q == '0 ? rx_byte == 8'h00 :
       rx_left_q == 11'h001);
   wire rx_crc_end = rx_byte_done && rx_st_q == RX_CRC && rx_crcb_q;
   wire rx_crc_good = {rx_got_q[7:0], rx_byte} == ~rx_crc_q;
   wire rx_fin = (rx_pay_end && !i_cfg.checksum_enable) || rx_crc_end;
   wire rx_keep = !i_cfg.checksum_enable || rx_crc_good ||
      i_cfg.checksum_fail_keep; // [RQ18]
   // Raw unlimited rx fills from sync event or always, per fill bit
   wire rx_start = rx_raw_mode ? (i_cfg.queue_fill_condition || rx_sync)
                               : rx_sync; // [RQ7]

   // Deframer
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rx_st_q <= RX_HUNT;
         rx_sh_q <= '0;
         rx_bit_q <= '0;
         rx_left_q <= '0;
         rx_idx_q <= '0;
         rx_half_q <= 1'b0;
         rx_crcb_q <= 1'b0;
         rx_crc_q <= RPH_CRC_SEED;
         rx_got_q <= '0;
         rx_lfsr_q <= RPH_WHITE_SEED;
         rx_ready_q <= 1'b0;
         rx_ok_q <= 1'b0;
      end else if (i_ce) begin
         if (i_tx_mode) begin
            rx_ready_q <= 1'b0;
            rx_ok_q <= 1'b0;
         end
         if (!i_rx_mode) begin
            rx_st_q <= RX_HUNT; // Flags persist unless tx mode; queue persists [RQ19]
         end else if (rx_st_q == RX_HUNT) begin
            if (rx_start) begin
               rx_st_q <= RX_PAY; // Preamble and sync dropped [RQ13]
               rx_bit_q <= '0;
               rx_idx_q <= '0;
               rx_half_q <= 1'b0;
               rx_crc_q <= RPH_CRC_SEED;
               rx_lfsr_q <= RPH_WHITE_SEED;
               rx_left_q <= i_cfg.payload_length_setting; // [RQ14]
               rx_ready_q <= 1'b0;
               rx_ok_q <= 1'b0;
            end
         end else begin
            if (rx_val && rx_manch) begin
               rx_half_q <= !rx_half_q;
            end
            if (rx_take) begin
               rx_sh_q <= rx_byte;
               rx_bit_q <= rx_bit_q + 3'h1;
               if (rx_dec) begin
                  rx_lfsr_q <= lfsr_step(rx_lfsr_q);
               end
               if (rx_st_q == RX_PAY) begin
                  rx_crc_q <= crc_step(rx_crc_q, rx_db);
               end
            end
            if (rx_pay_byte) begin
               rx_idx_q <= rx_idx_q + 11'h001;
               rx_left_q <= (fmt_var && rx_idx_q == '0) ?
                  RPH_LEN_W'(rx_byte) : rx_left_q - 11'h001; // [RQ15]
            end
            if (rx_abort) begin
               rx_st_q <= RX_HUNT;
            end else if (rx_pay_end) begin
               rx_st_q <= i_cfg.checksum_enable ? RX_CRC : RX_HUNT;
               rx_crcb_q <= 1'b0;
            end else if (rx_byte_done && rx_st_q == RX_CRC) begin
               rx_crcb_q <= 1'b1;
               rx_got_q <= {rx_got_q[7:0], rx_byte};
            end
            if (rx_crc_end) begin
               rx_st_q <= RX_HUNT;
               rx_ok_q <= rx_crc_good; // [RQ17]
            end
            if (rx_fin && !fmt_unlim) begin
               rx_ready_q <= rx_keep; // [RQ17] [RQ18] [RQ6]
            end
         end
      end
   end

   // Queue access: host writes tx data, deframer writes rx payload
   assign q_wr = i_ce && (i_rx_mode ? rx_pay_byte && !rx_abort : i_host_wr);
   assign q_wdata = i_rx_mode ? rx_byte : i_host_wdata;
   assign q_rd = i_tx_mode ? tx_pop : (i_ce && i_host_rd); // [RQ19]
   // Bad address or length, or failed CRC without keep, flushes the packet
   assign q_clr = (rx_abort || (rx_crc_end && !rx_keep)) && i_rx_mode;
   // [RQ18]

   // Registered outputs
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_host_rdata <= '0;
         o_tx_bit <= 1'b0;
         o_tx_bit_valid <= 1'b0;
         o_stat <= '0;
         o_event_pin_zero <= 1'b0;
      end else if (i_ce) begin
         o_host_rdata <= q_rdata;
         o_tx_bit <= tx_bit_q2;
         o_tx_bit_valid <= tx_val_q;
         o_stat.checksum_match_flag <= rx_ok_q;
         o_stat.rx_frame_complete_flag <= rx_ready_q;
         o_stat.tx_frame_done_flag <= tx_done_q; // [RQ22]
         o_stat.queue_level_flag <=
            q_cnt > RPH_CNT_W'(i_cfg.queue_threshold_setting);
         o_stat.queue_empty_flag <= (q_cnt == '0);
         o_stat.queue_full_flag <= (q_cnt == RPH_CNT_W'(DEPTH));
         o_event_pin_zero <= i_tx_mode ? tx_done_q : rx_ready_q; // [RQ17]
      end
   end
endmodule
`default_nettype wire

// ===== dv/rph_top_chk.sv
// Port assertions for the radio packet handler
`timescale 1ns/1ps
`default_nettype none
module rph_top_chk import rph_pkg::*; (
   // Clock, reset, enable
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // Configuration and mode
   input wire rph_cfg_t i_cfg,
   input wire logic i_tx_mode,
   input wire logic i_rx_mode,
   // Watched outputs
   input wire logic o_tx_bit_valid,
   input wire rph_stat_t o_stat,
   input wire logic o_event_pin_zero
);
   // Unlimited framing has no receive checks
   wire unlim = !i_cfg.frame_format_select
      && i_cfg.payload_length_setting == 11'h0;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);

   a_reset_quiet: assert property (
      $rose(i_nrst) |-> !o_tx_bit_valid && !o_event_pin_zero)
      else $error("output active just after reset");
   a_ready_framed: assert property (
      $rose(o_stat.rx_frame_complete_flag) |-> i_rx_mode && !unlim)
      else $error("frame complete outside framed receive");
   a_match_gated: assert property (
      $rose(o_stat.checksum_match_flag) |-> i_cfg.checksum_enable && !unlim)
      else $error("checksum match without checking");
   a_done_single: assert property (
      o_stat.tx_frame_done_flag && i_ce |=> !o_stat.tx_frame_done_flag)
      else $error("sent flag longer than one cycle");
   a_done_in_tx: assert property (
      $rose(o_stat.tx_frame_done_flag) |-> i_tx_mode && $past(i_tx_mode, 8))
      else $error("sent flag outside transmit");
   a_pin_ready: assert property (
      (i_rx_mode && o_stat.rx_frame_complete_flag)[*3] |-> o_event_pin_zero)
      else $error("event pin misses frame complete");
   a_idle_no_chip: assert property (
      (!i_tx_mode)[*3] |-> !o_tx_bit_valid)
      else $error("chips sent outside transmit");
   a_flags_disjoint: assert property (
      !(o_stat.queue_full_flag && o_stat.queue_empty_flag))
      else $error("queue full and empty together");
   a_ce_freeze: assert property (
      !i_ce |=> $stable(o_stat) && $stable(o_tx_bit_valid))
      else $error("state moved with enable low");
endmodule

bind rph_top rph_top_chk u_rph_top_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_cfg(i_cfg),
   .i_tx_mode(i_tx_mode), .i_rx_mode(i_rx_mode),
   .o_tx_bit_valid(o_tx_bit_valid), .o_stat(o_stat),
   .o_event_pin_zero(o_event_pin_zero)
);
`default_nettype wire

// ===== dv/rph_modem_model.sv
// Behavioural modem: collects sent chips, plays received bits
`timescale 1ns/1ps
`default_nettype none
module rph_modem_model (
   // Clock and enable
   input wire logic i_clk,
   input wire logic i_ce,
   // Chips from the framer
   input wire logic i_tx_bit,
   input wire logic i_tx_bit_valid,
   // Bits towards the deframer
   output logic o_rx_bit,
   output logic o_rx_bit_valid,
   output logic o_rx_sync_found
);
   logic [7:0] cap[$];
   logic [7:0] sh;
   int nb = 0, gap = 4;

   // Bytes gather MSB first; frozen cycles carry no chip
   always @(posedge i_clk)
      if (!i_tx_bit_valid)
         nb = 0;
      else if (i_ce) begin
         sh = {sh[6:0], i_tx_bit};
         nb++;
         if (nb == 8) begin
            cap.push_back(sh);
            nb = 0;
         end
      end

   initial
      {o_rx_bit, o_rx_bit_valid, o_rx_sync_found} = 3'h0;

   // Bit settles gap cycles before valid; idle shows inverse
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(negedge i_clk);
         o_rx_bit = b[i];
         repeat (gap) @(negedge i_clk);
         o_rx_bit_valid = 1'b1;
         repeat (gap) @(negedge i_clk);
         o_rx_bit_valid = 1'b0;
         o_rx_bit = ~b[i];
      end
   endtask

   task automatic frame(input logic on);
      @(negedge i_clk);
      o_rx_sync_found = on;
      repeat (gap) @(negedge i_clk);
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_rph_top.sv
// Self-checking bench for the radio packet handler
`timescale 1ns/1ps
`default_nettype none
module tb_rph_top import rph_pkg::*; ;
   // Receive cases and expected flags
   typedef struct packed {
      logic fmt;
      logic [10:0] len;
      logic crc;
      logic keep;
      logic bad;
      logic [1:0] adr;
      logic [3:0] n;
      logic rdy;
      logic ok;
   } rph_row_t;
   rph_row_t rows[8] = '{
      '{1'h0, 11'h4, 1'h1, 1'h0, 1'h0, 2'h0, 4'h4, 1'h1, 1'h1},
      '{1'h0, 11'h4, 1'h1, 1'h0, 1'h1, 2'h0, 4'h4, 1'h0, 1'h0},
      '{1'h0, 11'h4, 1'h1, 1'h1, 1'h1, 2'h0, 4'h4, 1'h1, 1'h0},
      '{1'h1, 11'ha, 1'h1, 1'h0, 1'h0, 2'h0, 4'h5, 1'h1, 1'h1},
      '{1'h1, 11'h3, 1'h1, 1'h0, 1'h0, 2'h0, 4'h5, 1'h0, 1'h0},
      '{1'h0, 11'h3, 1'h0, 1'h0, 1'h0, 2'h1, 4'h3, 1'h1, 1'h0},
      '{1'h0, 11'h3, 1'h0, 1'h0, 1'h0, 2'h2, 4'h3, 1'h0, 1'h0},
      '{1'h0, 11'h0, 1'h0, 1'h0, 1'h0, 2'h0, 4'h3, 1'h0, 1'h0}};
   logic clk, nrst, ce, tx_mode, rx_mode, wr, rd, tx_bit, tx_vld;
   logic rx_bit, rx_vld, rx_sync, evt;
   logic [7:0] wdata, rdata;
   rph_cfg_t cfg;
   rph_stat_t stat;
   logic [7:0] q[$];
   int err_count = 0, total_checks = 0, cycles = 0;

   rph_top u_rph_top (
      .i_clk(clk), .i_nrst(nrst), .i_ce(ce), .i_cfg(cfg),
      .i_tx_mode(tx_mode), .i_rx_mode(rx_mode), .i_host_wr(wr),
      .i_host_wdata(wdata), .i_host_rd(rd), .o_host_rdata(rdata),
      .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_vld), .i_rx_bit(rx_bit),
      .i_rx_bit_valid(rx_vld), .i_rx_sync_found(rx_sync),
      .o_stat(stat), .o_event_pin_zero(evt));
   rph_modem_model u_rph_modem_model (
      .i_clk(clk), .i_ce(ce), .i_tx_bit(tx_bit), .i_tx_bit_valid(tx_vld),
      .o_rx_bit(rx_bit), .o_rx_bit_valid(rx_vld),
      .o_rx_sync_found(rx_sync));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Hang guard well above the run length
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         wrap_up();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // One-cycle strobes with a gap between calls
   task automatic wr_byte(input logic [7:0] b);
      wr = 1'b1;
      wdata = b;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask
   task automatic rd_byte(output logic [7:0] b);
      b = rdata;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
   endtask
   task automatic wait_done();
      int k = 0;
      while (stat.tx_frame_done_flag !== 1'b1 && k < 3000) begin
         @(negedge clk);
         k++;
      end
      chk(8'(stat.tx_frame_done_flag), 8'h1);
   endtask
   // Preamble run, then exactly the bytes in q
   task automatic check_tx(input int pre, input logic exact);
      int n = 0;
      while (u_rph_modem_model.cap[n] === RPH_PREAMBLE_BYTE)
         n++;
      chk(8'(exact ? n == pre : n >= pre), 8'h1);
      chk(8'(u_rph_modem_model.cap.size() - n), 8'(q.size()));
      foreach (q[i])
         chk(u_rph_modem_model.cap[n + i], q[i]);
   endtask
   function automatic logic [15:0] crc_of(input logic [7:0] d[$]);
      logic [15:0] c = RPH_CRC_SEED;
      foreach (d[i])
         for (int b = 7; b >= 0; b--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i][b]) ? RPH_CRC_POLY : 16'h0);
      return ~c;
   endfunction
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial begin
      logic [7:0] b;
      logic [15:0] crc;
      {nrst, tx_mode, rx_mode, wr, rd, wdata} = '0;
      ce = 1'b1;
      cfg = '0;
      cfg.sync_word_enable = 1'h1;
      cfg.sync_value = {8{8'hc3}};
      cfg.preamble_len = 16'h2;
      cfg.own_station_id = 8'h5a;
      cfg.queue_threshold_setting = 6'h2;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      @(negedge clk);
      chk(8'({tx_vld, evt, stat.rx_frame_complete_flag}), 8'h0);
      $display("reset test done");
      for (int r = 0; r < 8; r++) begin
         cfg.frame_format_select = rows[r].fmt;
         cfg.payload_length_setting = rows[r].len;
         cfg.checksum_enable = rows[r].crc;
         cfg.checksum_fail_keep = rows[r].keep;
         cfg.addr_check_enable = rows[r].adr != 2'h0;
         u_rph_modem_model.gap = (r % 2) ? 9 : 4;
         q.delete();
         for (int i = 0; i < rows[r].n; i++)
            q.push_back(8'h30 + 8'(i));
         if (rows[r].fmt)
            q[0] = 8'(rows[r].n - 1);
         if (rows[r].adr != 2'h0)
            q[0] = (rows[r].adr == 2'h1) ? 8'h5a : 8'h11;
         crc = crc_of(q);
         if (rows[r].bad)
            crc[0] = ~crc[0];
         rx_mode = 1'b1;
         u_rph_modem_model.frame(1'b1);
         foreach (q[i])
            u_rph_modem_model.send_byte(q[i]);
         if (rows[r].crc) begin
            u_rph_modem_model.send_byte(crc[15:8]);
            u_rph_modem_model.send_byte(crc[7:0]);
         end
         u_rph_modem_model.frame(1'b0);
         repeat (40) @(negedge clk);
         chk(8'(stat.rx_frame_complete_flag), 8'(rows[r].rdy));
         chk(8'(stat.checksum_match_flag), 8'(rows[r].ok));
         chk(8'(evt), 8'(rows[r].rdy));
         rx_mode = 1'b0;
         // Drained in standby; a rejected frame leaves nothing
         if (rows[r].rdy || rows[r].len == 11'h0)
            foreach (q[i]) begin
               rd_byte(b);
               chk(b, q[i]);
            end
         repeat (3) @(negedge clk);
         chk(8'(stat.queue_empty_flag), 8'h1);
         $display("rx row %0d done", r);
      end
      // Fixed frame with checksum, prefilled, start on first byte
      cfg.payload_length_setting = 11'h3;
      cfg.checksum_enable = 1'h1;
      cfg.transmit_start_condition = 1'h1;
      q = '{8'h5a, 8'h01, 8'hfe};
      foreach (q[i])
         wr_byte(q[i]);
      chk(8'(stat.queue_level_flag), 8'h1);
      crc = crc_of(q);
      q.push_back(crc[15:8]);
      q.push_back(crc[7:0]);
      q.push_front(8'hc3);
      u_rph_modem_model.cap.delete();
      tx_mode = 1'b1;
      repeat (30) @(negedge clk);
      ce = 1'b0;
      repeat (5) @(negedge clk);
      ce = 1'b1;
      wait_done();
      tx_mode = 1'b0;
      check_tx(2, 1'b1);
      $display("fixed tx test done");
      // Variable frame held back until threshold plus one bytes
      cfg.frame_format_select = 1'h1;
      cfg.checksum_enable = 1'h0;
      cfg.transmit_start_condition = 1'h0;
      cfg.preamble_len = 16'h1;
      u_rph_modem_model.cap.delete();
      tx_mode = 1'b1;
      wr_byte(8'h02);
      wr_byte(8'h77);
      repeat (200) @(negedge clk);
      chk(8'(u_rph_modem_model.cap.size() > 4), 8'h1);
      foreach (u_rph_modem_model.cap[i])
         chk(u_rph_modem_model.cap[i], RPH_PREAMBLE_BYTE);
      wr_byte(8'h88);
      wait_done();
      tx_mode = 1'b0;
      q = '{8'hc3, 8'h02, 8'h77, 8'h88};
      check_tx(1, 1'b0);
      $display("variable tx test done");
      wrap_up();
   end
endmodule
`default_nettype wire
